//--- pkg/ipc_params.svh
/*
 * Constants for the interrupt priority controller: field positions, widths,
 * reset values and vector numbering.
 * Assumes inclusion by bare name from the package and the design files.
 */
`ifndef IPC_PARAMS_SVH
`define IPC_PARAMS_SVH

`define IPC_NUM_SOURCES 16
`define IPC_PRIO_W 3
`define IPC_VEC_W 8
`define IPC_LEVEL_W 4
`define IPC_FIRST_VECTOR 8'h08
`define IPC_TRAP_LEVEL 4'h8
`define IPC_SR_LEVEL_LSB 5
`define IPC_SR_LEVEL_MSB 7
`define IPC_SR_W 8
`define IPC_EXT_W 5
`define IPC_TRAPS_ONE_W 5
`define IPC_CTL_ONE_RESET 6'h00
`define IPC_CTL_TWO_RESET 7'h00
`define IPC_ALT_TABLE_OFFSET 8'h00

`endif

//--- pkg/ipc_pkg.sv
/*
 * Types shared by the interrupt priority controller files.
 * Assumes the constants header sits beside it on the include path.
 */
`include "ipc_params.svh"

package ipc_pkg;
    typedef logic [`IPC_PRIO_W-1:0] ipc_prio_type;
    typedef logic [`IPC_LEVEL_W-1:0] ipc_level_type;
    typedef logic [`IPC_VEC_W-1:0] ipc_vec_type;
    typedef enum logic [1:0] {
        IPC_IDLE,
        IPC_PRESENT,
        IPC_HOLD
    } ipc_state_type;
endpackage

//--- hdl/ipc_flag_bank.sv
/*
 * Per-source request flags: hardware set, software clear, set wins.
 * Assumes request pulses and clear strobes synchronous to CLK.
 */
`timescale 1ns/1ps
`include "ipc_params.svh"

module ipc_flag_bank #(
    parameter int N = `IPC_NUM_SOURCES
) (
    input wire logic clk,              // system clock
    input wire logic rst,              // synchronous reset
    input wire logic ce,               // clock enable
    input wire logic [N-1:0] req,      // source request pulses
    input wire logic [N-1:0] clr,      // software clear strobes
    input wire logic [N-1:0] wr_set,   // software set strobes
    output logic [N-1:0] flag          // request flags
);
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_flag
            wire next_flag = req[g] | wr_set[g] | (flag[g] & ~clr[g]);
            always_ff @(posedge clk) begin
                if (rst)
                    flag[g] <= 1'b0;
                else if (ce)
                    flag[g] <= next_flag;
            end
        end
    endgenerate

    a_set_beats_clear: assert property (@(posedge clk) disable iff (rst)
        (ce && |(req & clr)) |=> ((flag & $past(req & clr)) == $past(req & clr)))
        else $error("request lost against clear");
endmodule

//--- hdl/ipc_arbiter.sv
/*
 * Combinational pick of the highest priority eligible source.
 * Lowest index wins between equal priorities (natural order).
 */
`timescale 1ns/1ps
`include "ipc_params.svh"

module ipc_arbiter
    import ipc_pkg::*;
#(
    parameter int N = `IPC_NUM_SOURCES
) (
    input wire logic [N-1:0] eligible,                 // flag, enable and gates met
    input wire logic [N*`IPC_PRIO_W-1:0] prio,         // packed priorities
    output logic found,                                // some source eligible
    output logic [$clog2(N)-1:0] win_idx,              // winning index
    output ipc_prio_type win_prio                      // winner priority
);
    always_comb begin
        found = 1'b0;
        win_idx = '0;
        win_prio = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (eligible[i] && (!found || prio[i*`IPC_PRIO_W +: `IPC_PRIO_W] >= win_prio)) begin
                found = 1'b1;
                win_idx = i[$clog2(N)-1:0];
                win_prio = prio[i*`IPC_PRIO_W +: `IPC_PRIO_W];
            end
        end
    end
endmodule

//--- hdl/ipc_controller.sv
/*
 * Interrupt priority controller top: flags, enables, priorities, global
 * controls, trap status and the latched taken vector and level.
 * Assumes the core pulses TAKE_ACK when it vectors to IRQ_VECTOR and drives
 * software writes as one-cycle strobes; all inputs synchronous to CLK.
 */
// Overview of operation
// - each source flag set by hardware, cleared by software
// - each source has its own enable bit
// - three bit priority per source, seven levels
// - latch taken vector and new level on take
// - new level equals priority of serviced interrupt
// - bits allocated in vector order, source zero is vector 8
// - global enable gates all user requests
// - alternate vector table select bit
// - external request input behaviour controls
// - nesting disable plus trap flags in control one
// - control three holds auxiliary clock and loop-stack trap flags
// - control four holds software hard trap flag
// - status bits 7:5 give current level, software writable
// - fourth level bit read only, traps never masked
`timescale 1ns/1ps
`include "ipc_params.svh"

module ipc_controller
    import ipc_pkg::*;
#(
    parameter int N = `IPC_NUM_SOURCES,
    parameter int EXT_N = `IPC_EXT_W
) (
    input wire logic CLK,                                  // system clock
    input wire logic SYS_RST,                              // synchronous reset
    input wire logic CE,                                   // clock enable
    input wire logic [N-1:0] SRC_REQ,                      // source request pulses
    input wire logic [N-1:0] FLAG_CLR,                     // software flag clear
    input wire logic [N-1:0] FLAG_SET,                     // software flag set
    input wire logic ENABLE_WR,                            // enable write strobe
    input wire logic [N-1:0] ENABLE_DATA,                  // enable write data
    input wire logic PRIO_WR,                              // priority write strobe
    input wire logic [N*`IPC_PRIO_W-1:0] PRIO_DATA,        // priority write data
    input wire logic CTL_ONE_WR,                           // control one write
    input wire logic NESTING_DISABLE_IN,                   // nesting disable data
    input wire logic CTL_TWO_WR,                           // control two write
    input wire logic GLOBAL_ENABLE_IN,                     // global enable data
    input wire logic ALT_TABLE_IN,                         // alternate table data
    input wire logic [EXT_N-1:0] EXT_EDGE_IN,              // external edge polarity
    input wire logic [EXT_N-1:0] EXT_PIN,                  // external request pins
    input wire logic [`IPC_TRAPS_ONE_W-1:0] TRAP_EVENT,    // core trap pulses
    input wire logic [`IPC_TRAPS_ONE_W-1:0] TRAP_CLR,      // trap flag clears
    input wire logic AUX_PLL_TRAP,                         // auxiliary clock trap
    input wire logic LOOP_STACK_TRAP,                      // loop stack overflow
    input wire logic [1:0] CTL_THREE_CLR,                  // control three clears
    input wire logic SOFT_HARD_TRAP,                       // software hard trap
    input wire logic SOFT_HARD_TRAP_CLR,                   // clear it
    input wire logic SR_WR,                                // status level write
    input wire logic [`IPC_SR_W-1:0] SR_DATA,              // status write data
    input wire logic TAKE_ACK,                             // core takes interrupt
    input wire logic RETURN_LEVEL_WR,                      // core restores level
    input wire logic [`IPC_LEVEL_W-1:0] RETURN_LEVEL,      // restored level
    output logic [N-1:0] FLAGS,                            // request flags
    output logic [N-1:0] ENABLES,                          // enable bits
    output logic [N*`IPC_PRIO_W-1:0] PRIORITIES,           // priority fields
    output logic NESTING_DISABLE,                          // nesting disabled
    output logic GLOBAL_ENABLE,                            // global enable
    output logic ALT_TABLE,                                // alternate table
    output logic [EXT_N-1:0] EXT_EDGE,                     // edge polarity
    output logic [`IPC_TRAPS_ONE_W-1:0] TRAP_FLAGS,        // control one traps
    output logic [1:0] CTL_THREE_FLAGS,                    // aux pll, loop stack
    output logic SOFT_TRAP_FLAG,                           // control four flag
    output logic [`IPC_SR_W-1:0] CPU_STATUS,               // status register
    output logic CPU_LEVEL_TOP,                            // read only level bit
    output logic IRQ_VALID,                                // request to core
    output logic [`IPC_VEC_W-1:0] IRQ_VECTOR,              // vector offered
    output logic [`IPC_VEC_W-1:0] TAKEN_VECTOR,            // latched vector
    output logic [`IPC_LEVEL_W-1:0] TAKEN_LEVEL            // latched new level
);
    localparam int IW = $clog2(N);

    logic [N-1:0] flag;
    logic [EXT_N-1:0] ext_prev;
    logic [N-1:0] ext_req;
    logic [N-1:0] eligible;
    logic found;
    logic [IW-1:0] win_idx;
    ipc_prio_type win_prio;
    ipc_level_type cur_level;
    ipc_level_type win_level;
    ipc_state_type state;
    ipc_state_type next_state;
    logic [`IPC_VEC_W-1:0] win_vector;
    ipc_level_type take_level;

    // level of the vector on offer, reused by the latch and the status update
    assign take_level = level_of(IRQ_VECTOR);

    // external pins edge detect; polarity per pin from control two
    wire [EXT_N-1:0] ext_edge_hit =
        (EXT_PIN & ~ext_prev & ~EXT_EDGE) | (~EXT_PIN & ext_prev & EXT_EDGE);

    // external requests occupy the lowest source slots in vector order
    assign ext_req = SRC_REQ | {{(N-EXT_N){1'b0}}, ext_edge_hit};

    ipc_flag_bank #(.N(N)) u_flags (
        .clk(CLK),
        .rst(SYS_RST),
        .ce(CE),
        .req(ext_req),
        .clr(FLAG_CLR),
        .wr_set(FLAG_SET),
        .flag(flag)
    );

    assign cur_level = {CPU_LEVEL_TOP, CPU_STATUS[`IPC_SR_LEVEL_MSB:`IPC_SR_LEVEL_LSB]};

    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_elig
            // nesting disabled: anything in service blocks further requests
            assign eligible[g] = flag[g] & ENABLES[g] & GLOBAL_ENABLE
                & ({1'b0, PRIORITIES[g*`IPC_PRIO_W +: `IPC_PRIO_W]} > cur_level)
                & !(NESTING_DISABLE && cur_level != 4'h0);
        end
    endgenerate

    ipc_arbiter #(.N(N)) u_arb (
        .eligible(eligible),
        .prio(PRIORITIES),
        .found(found),
        .win_idx(win_idx),
        .win_prio(win_prio)
    );

    assign win_level = {1'b0, win_prio};
    // alternate table adds IPC_ALT_TABLE_OFFSET, which is zero, so vectors stay put
    assign win_vector = `IPC_FIRST_VECTOR + {{(`IPC_VEC_W-IW){1'b0}}, win_idx}
        + (ALT_TABLE ? `IPC_ALT_TABLE_OFFSET : 8'h00);

    always_comb begin
        next_state = state;
        case (state)
            IPC_IDLE: if (found) next_state = IPC_PRESENT;
            IPC_PRESENT: next_state = TAKE_ACK ? IPC_HOLD : (found ? IPC_PRESENT : IPC_IDLE);
            IPC_HOLD: next_state = IPC_IDLE;
            default: next_state = IPC_IDLE;
        endcase
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            state <= IPC_IDLE;
            IRQ_VALID <= 1'b0;
            IRQ_VECTOR <= 8'h00;
            ext_prev <= '0;
        end else if (CE) begin
            state <= next_state;
            // offer only while presenting, so the hold cycle never shows a request
            IRQ_VALID <= (next_state == IPC_PRESENT);
            IRQ_VECTOR <= win_vector;
            ext_prev <= EXT_PIN;
        end
    end

    // taken vector and level latch on acceptance
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            TAKEN_VECTOR <= 8'h00;
            TAKEN_LEVEL <= 4'h0;
        end else if (CE && state == IPC_PRESENT && TAKE_ACK) begin
            TAKEN_VECTOR <= IRQ_VECTOR;
            TAKEN_LEVEL <= take_level;
        end
    end

    // priority of the offered vector; function avoids duplicating the decode
    function automatic ipc_level_type level_of(input logic [`IPC_VEC_W-1:0] v);
        logic [`IPC_VEC_W-1:0] rel;
        rel = v - `IPC_FIRST_VECTOR - (ALT_TABLE ? `IPC_ALT_TABLE_OFFSET : 8'h00);
        level_of = {1'b0, PRIORITIES[rel[IW-1:0]*`IPC_PRIO_W +: `IPC_PRIO_W]};
    endfunction

    // control and enable registers
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            ENABLES <= '0;
            PRIORITIES <= '0;
            {NESTING_DISABLE, GLOBAL_ENABLE, ALT_TABLE} <= 3'h0;
            EXT_EDGE <= '0;
        end else if (CE) begin
            if (ENABLE_WR)
                ENABLES <= ENABLE_DATA;
            if (PRIO_WR)
                PRIORITIES <= PRIO_DATA;
            if (CTL_ONE_WR)
                NESTING_DISABLE <= NESTING_DISABLE_IN;
            if (CTL_TWO_WR) begin
                GLOBAL_ENABLE <= GLOBAL_ENABLE_IN;
                ALT_TABLE <= ALT_TABLE_IN;
                EXT_EDGE <= EXT_EDGE_IN;
            end
        end
    end

    // trap status: events win over clears
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            TRAP_FLAGS <= '0;
            CTL_THREE_FLAGS <= 2'h0;
            SOFT_TRAP_FLAG <= 1'b0;
        end else if (CE) begin
            TRAP_FLAGS <= TRAP_EVENT | (TRAP_FLAGS & ~TRAP_CLR);
            CTL_THREE_FLAGS <= {AUX_PLL_TRAP, LOOP_STACK_TRAP}
                | (CTL_THREE_FLAGS & ~CTL_THREE_CLR);
            SOFT_TRAP_FLAG <= SOFT_HARD_TRAP | (SOFT_TRAP_FLAG & ~SOFT_HARD_TRAP_CLR);
        end
    end

    // current level: core sets it on take or return, software only low bits
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            CPU_STATUS <= 8'h00;
            CPU_LEVEL_TOP <= 1'b0;
        end else if (CE) begin
            if (state == IPC_PRESENT && TAKE_ACK) begin
                CPU_STATUS[`IPC_SR_LEVEL_MSB:`IPC_SR_LEVEL_LSB] <= take_level[2:0];
            end else if (RETURN_LEVEL_WR) begin
                CPU_STATUS[`IPC_SR_LEVEL_MSB:`IPC_SR_LEVEL_LSB] <= RETURN_LEVEL[2:0];
                CPU_LEVEL_TOP <= RETURN_LEVEL[3];
            end else if (SR_WR) begin
                CPU_STATUS <= SR_DATA;
            end
        end
    end

    assign FLAGS = flag;

    a_latch_on_take: assert property (@(posedge CLK) disable iff (SYS_RST)
        (CE && state == IPC_PRESENT && TAKE_ACK) |=> TAKEN_VECTOR == $past(IRQ_VECTOR))
        else $error("taken vector not latched");
    a_level_matches: assert property (@(posedge CLK) disable iff (SYS_RST)
        (CE && state == IPC_PRESENT && TAKE_ACK) |=>
        TAKEN_LEVEL[2:0] == CPU_STATUS[`IPC_SR_LEVEL_MSB:`IPC_SR_LEVEL_LSB])
        else $error("new level differs from serviced priority");
    a_gated_global: assert property (@(posedge CLK) disable iff (SYS_RST)
        (CE && !GLOBAL_ENABLE) |=> !IRQ_VALID)
        else $error("request offered while globally disabled");
    a_above_level: assert property (@(posedge CLK) disable iff (SYS_RST)
        (CE && found) |-> {1'b0, win_prio} > cur_level)
        else $error("winner not above current level");
    a_top_read_only: assert property (@(posedge CLK) disable iff (SYS_RST)
        (CE && SR_WR && !RETURN_LEVEL_WR) |=> $stable(CPU_LEVEL_TOP))
        else $error("software changed read only level bit");
    a_status_write: assert property (@(posedge CLK) disable iff (SYS_RST)
        (CE && SR_WR && !RETURN_LEVEL_WR && !(state == IPC_PRESENT && TAKE_ACK))
        |=> CPU_STATUS == $past(SR_DATA))
        else $error("status level write lost");
    a_enable_blocks: assert property (@(posedge CLK) disable iff (SYS_RST)
        found |-> ENABLES[win_idx])
        else $error("disabled source won");
    a_trap_sticky: assert property (@(posedge CLK) disable iff (SYS_RST)
        (CE && AUX_PLL_TRAP) |=> CTL_THREE_FLAGS[1])
        else $error("aux clock trap not recorded");
    a_soft_trap: assert property (@(posedge CLK) disable iff (SYS_RST)
        (CE && SOFT_HARD_TRAP) |=> SOFT_TRAP_FLAG)
        else $error("software trap not recorded");
endmodule

//--- dv/ipc_core_model.sv
/*
 * Behavioural core: takes the offered vector, promptly or after a delay.
 * Assumes IRQ_VALID registered on CLK; drives take_ack at the falling edge.
 */
`timescale 1ns/1ps

module ipc_core_model (
    input wire logic clk,         // system clock
    input wire logic rst,         // synchronous reset
    input wire logic irq_valid,   // request offered
    input wire logic accept_en,   // core willing to take
    input wire logic [3:0] delay, // cycles to stall before taking
    output logic take_ack         // one cycle take pulse
);
    int wait_cnt;

    initial begin
        take_ack = 1'b0;
        wait_cnt = 0;
    end

    // one pulse per offer; the drop of the offer restarts the stall count
    always @(negedge clk) begin
        if (rst || take_ack || !irq_valid || !accept_en) begin
            take_ack <= 1'b0;
            wait_cnt <= 0;
        end else if (wait_cnt >= delay) begin
            take_ack <= 1'b1;
        end else begin
            wait_cnt <= wait_cnt + 1;
        end
    end
endmodule

//--- dv/interrupt_priority_controller_tb_top.sv
/*
 * Self-checking bench for the interrupt priority controller.
 * Assumes the core model file is compiled first; inputs change at negedge.
 */
`timescale 1ns/1ps
`include "ipc_params.svh"

module interrupt_priority_controller_tb_top;
    import ipc_pkg::*;
    logic CLK, SYS_RST, CE, ENABLE_WR, PRIO_WR, CTL_ONE_WR, NESTING_DISABLE_IN, CTL_TWO_WR;
    logic GLOBAL_ENABLE_IN, ALT_TABLE_IN, AUX_PLL_TRAP, LOOP_STACK_TRAP, SOFT_HARD_TRAP;
    logic SOFT_HARD_TRAP_CLR, SR_WR, TAKE_ACK, RETURN_LEVEL_WR, accept_en;
    logic [15:0] SRC_REQ, FLAG_CLR, FLAG_SET, ENABLE_DATA, FLAGS, ENABLES;
    logic [47:0] PRIO_DATA, PRIORITIES;
    logic [4:0] EXT_EDGE_IN, EXT_PIN, TRAP_EVENT, TRAP_CLR, EXT_EDGE, TRAP_FLAGS;
    logic [1:0] CTL_THREE_CLR, CTL_THREE_FLAGS;
    logic [7:0] SR_DATA, CPU_STATUS, IRQ_VECTOR, TAKEN_VECTOR;
    logic [3:0] RETURN_LEVEL, TAKEN_LEVEL, delay;
    logic NESTING_DISABLE, GLOBAL_ENABLE, ALT_TABLE, SOFT_TRAP_FLAG, CPU_LEVEL_TOP, IRQ_VALID;
    logic [31:0] seed = 32'h0000003B;
    int n_fail = 0;
    int check_count = 0;

    ipc_controller DUT (.CLK, .SYS_RST, .CE, .SRC_REQ, .FLAG_CLR, .FLAG_SET, .ENABLE_WR,
        .ENABLE_DATA, .PRIO_WR, .PRIO_DATA, .CTL_ONE_WR, .NESTING_DISABLE_IN, .CTL_TWO_WR,
        .GLOBAL_ENABLE_IN, .ALT_TABLE_IN, .EXT_EDGE_IN, .EXT_PIN, .TRAP_EVENT, .TRAP_CLR,
        .AUX_PLL_TRAP, .LOOP_STACK_TRAP, .CTL_THREE_CLR, .SOFT_HARD_TRAP, .SOFT_HARD_TRAP_CLR,
        .SR_WR, .SR_DATA, .TAKE_ACK, .RETURN_LEVEL_WR, .RETURN_LEVEL, .FLAGS, .ENABLES,
        .PRIORITIES, .NESTING_DISABLE, .GLOBAL_ENABLE, .ALT_TABLE, .EXT_EDGE, .TRAP_FLAGS,
        .CTL_THREE_FLAGS, .SOFT_TRAP_FLAG, .CPU_STATUS, .CPU_LEVEL_TOP, .IRQ_VALID,
        .IRQ_VECTOR, .TAKEN_VECTOR, .TAKEN_LEVEL);

    ipc_core_model core (.clk(CLK), .rst(SYS_RST), .irq_valid(IRQ_VALID),
        .accept_en(accept_en), .delay(delay), .take_ack(TAKE_ACK));

    initial begin
        CLK = 1'b0;
        forever #2.5 CLK = ~CLK;
    end

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // expected {valid, vector}: highest priority above level, lowest index on ties
    function automatic logic [8:0] exp_win(logic [15:0] f, logic [15:0] en, logic [47:0] p,
                                           logic [2:0] lvl, logic g, logic nest);
        logic [8:0] r;
        logic [2:0] best;
        r = 9'h000;
        best = 3'h0;
        for (int i = 0; i < 16; i++) begin
            if (f[i] && en[i] && g && !(nest && lvl != 3'h0) && p[3*i+:3] > lvl
                && (!r[8] || p[3*i+:3] > best)) begin
                best = p[3*i+:3];
                r = {1'b1, 8'h08 + 8'(i)};
            end
        end
        return r;
    endfunction

    task automatic tick(int n);
        repeat (n) @(negedge CLK);
    endtask

    task automatic chk(logic [47:0] got, logic [47:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic strobe_clear();
        {SRC_REQ, FLAG_CLR, FLAG_SET, ENABLE_WR, PRIO_WR, CTL_ONE_WR, CTL_TWO_WR, SR_WR} = '0;
        {TRAP_EVENT, TRAP_CLR, AUX_PLL_TRAP, LOOP_STACK_TRAP, CTL_THREE_CLR} = '0;
        {SOFT_HARD_TRAP, SOFT_HARD_TRAP_CLR} = '0;
    endtask

    initial begin
        logic [15:0] f, en;
        logic [47:0] p;
        logic [31:0] r;
        logic [8:0] e;
        strobe_clear();
        {CE, SYS_RST, accept_en, delay} = {1'b1, 1'b1, 1'b0, 4'h2};
        {ENABLE_DATA, PRIO_DATA, NESTING_DISABLE_IN, GLOBAL_ENABLE_IN, ALT_TABLE_IN} = '0;
        {EXT_EDGE_IN, EXT_PIN, SR_DATA, RETURN_LEVEL_WR, RETURN_LEVEL} = '0;
        tick(10);
        SYS_RST = 1'b0;
        chk({FLAGS, ENABLES, TAKEN_VECTOR, TAKEN_LEVEL, IRQ_VALID}, 48'h0);
        $display("test reset done");
        // walk: source 3 at priority 5, taken by a slow core
        {ENABLE_WR, ENABLE_DATA, PRIO_WR, PRIO_DATA} = {1'b1, 16'hFFFF, 1'b1, 48'h0A00};
        {CTL_TWO_WR, GLOBAL_ENABLE_IN, ALT_TABLE_IN, accept_en} = 4'hF;
        tick(1);
        strobe_clear();
        SRC_REQ = 16'h0008;
        tick(1);
        SRC_REQ = 16'h0000;
        chk(FLAGS, 48'h0008);
        tick(1);
        chk({IRQ_VALID, IRQ_VECTOR}, 48'h10B);
        chk(ALT_TABLE, 48'h1);
        for (int k = 0; k < 20 && TAKEN_VECTOR !== 8'h0B; k++) tick(1);
        chk({TAKEN_VECTOR, TAKEN_LEVEL}, 48'hB5);
        chk({CPU_STATUS[7:5], IRQ_VALID}, 48'hA);
        chk(FLAGS, 48'h0008);
        {accept_en, FLAG_CLR, SR_WR, SR_DATA} = {1'b0, 16'h0008, 1'b1, 8'hE0};
        tick(1);
        strobe_clear();
        tick(1);
        chk({FLAGS, CPU_STATUS[7:5], CPU_LEVEL_TOP}, 48'h0E);
        $display("test walk done");
        for (int it = 0; it < 200; it++) begin
            f = xs();
            en = xs();
            p = 48'({xs(), xs()});
            r = xs();
            {FLAG_SET, FLAG_CLR, ENABLE_WR, ENABLE_DATA, PRIO_WR, PRIO_DATA} = {f, ~f, 1'b1, en, 1'b1, p};
            {SR_WR, SR_DATA, CTL_ONE_WR, NESTING_DISABLE_IN} = {1'b1, r[2:0], 5'h00, 1'b1, r[3]};
            {CTL_TWO_WR, GLOBAL_ENABLE_IN, ALT_TABLE_IN, EXT_EDGE_IN} = {1'b1, r[11] | r[4], r[10:5]};
            tick(1);
            strobe_clear();
            tick(1);
            e = exp_win(f, en, p, r[2:0], r[11] | r[4], r[3]);
            chk({ENABLES, PRIORITIES}, {en, p});
            chk({NESTING_DISABLE, GLOBAL_ENABLE, ALT_TABLE, EXT_EDGE}, {r[3], r[11] | r[4], r[10:5]});
            // idle arbiter points at the first slot
            chk({IRQ_VALID, IRQ_VECTOR}, e[8] ? e : {1'b0, 8'h08});
        end
        $display("test random done");
        {TRAP_EVENT, AUX_PLL_TRAP, LOOP_STACK_TRAP, SOFT_HARD_TRAP} = 8'hAF;
        tick(1);
        strobe_clear();
        {TRAP_CLR, CTL_THREE_CLR, SOFT_HARD_TRAP_CLR} = 8'h2D;
        chk({TRAP_FLAGS, CTL_THREE_FLAGS, SOFT_TRAP_FLAG}, 48'hAF);
        tick(1);
        strobe_clear();
        chk({TRAP_FLAGS, CTL_THREE_FLAGS, SOFT_TRAP_FLAG}, 48'h82);
        {CTL_TWO_WR, EXT_EDGE_IN, FLAG_CLR} = {1'b1, 5'h00, 16'hFFFF};
        tick(1);
        strobe_clear();
        EXT_PIN = 5'h01;
        tick(3);
        chk(FLAGS[0], 48'h1);
        $display("test traps and pins done");
        report_and_stop();
    end

    initial begin
        #(5 * 5000);
        n_fail++;
        report_and_stop();
    end
endmodule
